// *** hw/rrx_pkg.sv ***
// Shared constants, opcodes and rotate helpers for the return and rotate execution block.
package rrx_pkg;

  // ------------------------------------------------------------
  // Widths and sizes
  // ------------------------------------------------------------
  localparam int RRX_DATA_W      = 8;
  localparam int RRX_ADDR_W      = 8;
  localparam int RRX_PC_W        = 13;
  localparam int RRX_STACK_DEPTH = 8;
  localparam int RRX_LEVEL_W     = 4;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic                  RRX_MIE_RST   = 1'h0;
  localparam logic [RRX_DATA_W-1:0] RRX_DATA_RST  = 8'h00;
  localparam logic [RRX_PC_W-1:0]   RRX_PC_RST    = 13'h0000;
  localparam logic [RRX_LEVEL_W-1:0] RRX_LEVEL_RST = 4'h0;

  // ------------------------------------------------------------
  // Instruction codes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_SUBROUTINE_EXIT_WITH_LITERAL = 4'h0,
    OP_INTERRUPT_EXIT               = 4'h1,
    OP_ROTATE_LEFT_MEM              = 4'h2,
    OP_ROTATE_LEFT_TO_WORK          = 4'h3,
    OP_ROTATE_LEFT_VIA_FLAG_MEM     = 4'h4,
    OP_ROTATE_LEFT_VIA_FLAG_TO_WORK = 4'h5,
    OP_ROTATE_RIGHT_MEM             = 4'h6,
    OP_ROTATE_RIGHT_TO_WORK         = 4'h7,
    OP_ROTATE_RIGHT_VIA_FLAG_MEM    = 4'h8
  } rrx_op_t;

  // ------------------------------------------------------------
  // Rotate helpers and return decode
  // ------------------------------------------------------------
  function automatic logic [7:0] rrx_rol(input logic [7:0] d);
    rrx_rol = {d[6:0], d[7]};
  endfunction

  function automatic logic [7:0] rrx_ror(input logic [7:0] d);
    rrx_ror = {d[0], d[7:1]};
  endfunction

  function automatic logic [7:0] rrx_rolc(input logic [7:0] d, input logic c);
    rrx_rolc = {d[6:0], c};
  endfunction

  function automatic logic [7:0] rrx_rorc(input logic [7:0] d, input logic c);
    rrx_rorc = {c, d[7:1]};
  endfunction

  function automatic logic rrx_is_return(input rrx_op_t op);
    rrx_is_return = (op == OP_SUBROUTINE_EXIT_WITH_LITERAL) || (op == OP_INTERRUPT_EXIT);
  endfunction

endpackage

// *** hw/rrx_rotator.sv ***
// Combinational rotate unit: result, carry out, destination and carry write enable.
`timescale 1ns/1ns
module rrx_rotator
  import rrx_pkg::*;
(
  input  wire rrx_op_t    i_op,
  input  wire logic [7:0] i_data,
  input  wire logic       i_carry,
  output logic [7:0]      o_result,
  output logic            o_carry,
  output logic            o_to_mem,
  output logic            o_flag_we
);

  always_comb
  begin
    o_result  = i_data;
    o_carry   = i_carry;
    o_to_mem  = 1'b0;
    o_flag_we = 1'b0;
    case (i_op)
      OP_ROTATE_LEFT_MEM:
      begin
        o_result = rrx_rol(i_data);
        o_to_mem = 1'b1;
      end
      OP_ROTATE_LEFT_TO_WORK:
      begin
        o_result = rrx_rol(i_data);
      end
      OP_ROTATE_LEFT_VIA_FLAG_MEM:
      begin
        o_result  = rrx_rolc(i_data, i_carry);
        o_carry   = i_data[7];
        o_to_mem  = 1'b1;
        o_flag_we = 1'b1;
      end
      OP_ROTATE_LEFT_VIA_FLAG_TO_WORK:
      begin
        o_result  = rrx_rolc(i_data, i_carry);
        o_carry   = i_data[7];
        o_flag_we = 1'b1;
      end
      OP_ROTATE_RIGHT_MEM:
      begin
        o_result = rrx_ror(i_data);
        o_to_mem = 1'b1;
      end
      OP_ROTATE_RIGHT_TO_WORK:
      begin
        o_result = rrx_ror(i_data);
      end
      OP_ROTATE_RIGHT_VIA_FLAG_MEM:
      begin
        o_result  = rrx_rorc(i_data, i_carry);
        o_carry   = i_data[0];
        o_to_mem  = 1'b1;
        o_flag_we = 1'b1;
      end
      default:
      begin
        o_result = i_data;
      end
    endcase
  end

endmodule

// *** hw/rrx_stack.sv ***
// Hardware return-address stack with push, pop and replace-on-both.
`timescale 1ns/1ns
module rrx_stack
  import rrx_pkg::*;
(
  input  wire logic                   i_mclk,
  input  wire logic                   i_nrst,
  input  wire logic                   i_push,
  input  wire logic [RRX_PC_W-1:0]    i_push_pc,
  input  wire logic                   i_pop,
  output logic      [RRX_PC_W-1:0]    o_top,
  output logic      [RRX_LEVEL_W-1:0] o_level
);

  logic [RRX_PC_W-1:0]    entry [RRX_STACK_DEPTH];
  logic [RRX_LEVEL_W-1:0] level;
  logic [RRX_LEVEL_W-1:0] top_idx;
  logic                   do_pop;
  logic                   do_push;

  // A pop on an empty stack is ignored and yields entry 0; a push on a full
  // stack is dropped, so the oldest return addresses are never overwritten.
  assign do_pop  = i_pop && (level != RRX_LEVEL_RST);
  assign do_push = i_push && ((level < RRX_LEVEL_W'(RRX_STACK_DEPTH)) || do_pop);
  assign top_idx = (level == RRX_LEVEL_RST) ? RRX_LEVEL_RST : level - 4'h1;
  assign o_top   = entry[top_idx[2:0]];
  assign o_level = level;

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      level <= RRX_LEVEL_RST;
    else if (do_pop && !do_push)
      level <= level - 4'h1;
    else if (do_push && !do_pop)
      level <= level + 4'h1;
  end

  always_ff @(posedge i_mclk)
  begin
    if (do_push)
      entry[do_pop ? top_idx[2:0] : level[2:0]] <= i_push_pc;
  end

endmodule

// *** hw/rrx_exec.sv ***
// Execution sequencer for the return-type and rotate instructions.
// Overview of operation
// - Literal subroutine exit pops PC, loads immediate into working register, flags kept.
// - Interrupt exit pops PC, sets master interrupt enable to 1, flags kept.
// - Interrupt exit with pending interrupt services that interrupt before main program.
// - Rotate left memory: bit 7 to bit 0, written back, no flag change.
// - Rotate left to working register: memory untouched, no flag change.
// - Rotate left via carry to memory: bit 7 to carry, old carry to bit 0.
// - Rotate left via carry to working register, carry from bit 7, memory kept.
// - Rotate right memory: bit 0 to bit 7, written back, no flag change.
// - Rotate right to working register: memory untouched, no flag change.
// - Rotate right via carry to memory: bit 0 to carry, old carry to bit 7.
`timescale 1ns/1ns
module rrx_exec
  import rrx_pkg::*;
(
  input  wire logic                  i_mclk,
  input  wire logic                  i_nrst,
  input  wire logic                  i_start,
  input  wire rrx_op_t               i_op,
  input  wire logic [RRX_DATA_W-1:0] i_imm,
  input  wire logic [RRX_ADDR_W-1:0] i_addr,
  input  wire logic [RRX_DATA_W-1:0] i_mem_rdata,
  input  wire logic                  i_carry,
  input  wire logic                  i_push,
  input  wire logic [RRX_PC_W-1:0]   i_push_pc,
  input  wire logic                  i_mie_clr,
  input  wire logic                  i_irq_pending,
  input  wire logic [RRX_PC_W-1:0]   i_irq_vector,
  output logic                       o_busy,
  output logic                       o_done,
  output logic                       o_mem_rd,
  output logic                       o_mem_wr,
  output logic [RRX_ADDR_W-1:0]      o_mem_addr,
  output logic [RRX_DATA_W-1:0]      o_mem_wdata,
  output logic                       o_work_we,
  output logic [RRX_DATA_W-1:0]      o_work,
  output logic                       o_carry_we,
  output logic                       o_carry,
  output logic                       o_pc_load,
  output logic [RRX_PC_W-1:0]        o_pc,
  output logic                       o_irq_take,
  output logic                       o_mie
);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_READ  = 4'h2,
    S_WRITE = 4'h4,
    S_RET   = 4'h8
  } rrx_state_t;

  rrx_state_t                state;
  rrx_state_t                next_state;
  rrx_op_t                   op;
  logic [RRX_DATA_W-1:0]     imm;
  logic [RRX_DATA_W-1:0]     rot_result;
  logic                      rot_carry;
  logic                      rot_to_mem;
  logic                      rot_flag_we;
  logic                      stk_pop;
  logic [RRX_PC_W-1:0]       stk_top;
  logic [RRX_LEVEL_W-1:0]    stk_level;
  logic                      iret_to_irq;

  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE:
      begin
        if (i_start)
          next_state = rrx_is_return(i_op) ? S_RET : S_READ;
      end
      S_READ:
        next_state = S_WRITE;
      S_WRITE:
        next_state = S_IDLE;
      S_RET:
        next_state = S_IDLE;
      default:
        next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      op  <= OP_SUBROUTINE_EXIT_WITH_LITERAL;
      imm <= RRX_DATA_RST;
    end
    else if (state == S_IDLE && i_start)
    begin
      op  <= i_op;
      imm <= i_imm;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_busy <= (next_state != S_IDLE);
      o_done <= (state == S_WRITE) || (state == S_RET);
    end
  end

  // ------------------------------------------------------------
  // Rotate datapath
  // ------------------------------------------------------------
  rrx_rotator u_rot (
    .i_op      (op),
    .i_data    (i_mem_rdata),
    .i_carry   (i_carry),
    .o_result  (rot_result),
    .o_carry   (rot_carry),
    .o_to_mem  (rot_to_mem),
    .o_flag_we (rot_flag_we)
  );

  // The read is issued one cycle after the start so the address comes from a
  // register; the memory returns the byte in the following cycle.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_mem_rd    <= 1'b0;
      o_mem_wr    <= 1'b0;
      o_mem_addr  <= '0;
      o_mem_wdata <= RRX_DATA_RST;
    end
    else
    begin
      o_mem_rd <= (state == S_IDLE) && i_start && !rrx_is_return(i_op);
      o_mem_wr <= (state == S_WRITE) && rot_to_mem;
      if (state == S_IDLE && i_start)
        o_mem_addr <= i_addr;
      if (state == S_WRITE)
        o_mem_wdata <= rot_result;
    end
  end

  // Only the via-carry forms touch the carry; all other flags are never driven.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_carry_we <= 1'b0;
      o_carry    <= 1'b0;
    end
    else
    begin
      o_carry_we <= (state == S_WRITE) && rot_flag_we;
      if (state == S_WRITE)
        o_carry <= rot_carry;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_work_we <= 1'b0;
      o_work    <= RRX_DATA_RST;
    end
    else if (state == S_WRITE && !rot_to_mem)
    begin
      o_work_we <= 1'b1;
      o_work    <= rot_result;
    end
    else if (state == S_RET && op == OP_SUBROUTINE_EXIT_WITH_LITERAL)
    begin
      o_work_we <= 1'b1;
      o_work    <= imm;
    end
    else
      o_work_we <= 1'b0;
  end

  // ------------------------------------------------------------
  // Return handling
  // ------------------------------------------------------------
  // A pending interrupt at the interrupt exit leaves the return address on
  // the stack and vectors at once, so the main program resumes only after
  // the pending routine has itself returned.
  assign iret_to_irq = (op == OP_INTERRUPT_EXIT) && i_irq_pending;
  assign stk_pop     = (state == S_RET) && !iret_to_irq;

  rrx_stack u_stack (
    .i_mclk    (i_mclk),
    .i_nrst    (i_nrst),
    .i_push    (i_push),
    .i_push_pc (i_push_pc),
    .i_pop     (stk_pop),
    .o_top     (stk_top),
    .o_level   (stk_level)
  );

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_pc_load  <= 1'b0;
      o_pc       <= RRX_PC_RST;
      o_irq_take <= 1'b0;
    end
    else
    begin
      o_pc_load  <= (state == S_RET);
      o_irq_take <= (state == S_RET) && iret_to_irq;
      if (state == S_RET)
        o_pc <= iret_to_irq ? i_irq_vector : stk_top;
    end
  end

  // The exit sets the enable even if an interrupt entry clears it in the
  // same cycle; a serviced pending interrupt keeps it cleared as on entry.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_mie <= RRX_MIE_RST;
    else if (state == S_RET && op == OP_INTERRUPT_EXIT)
      o_mie <= !i_irq_pending;
    else if (i_mie_clr)
      o_mie <= 1'b0;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  chk_literal_exit: assert property (
    (state == S_RET && op == OP_SUBROUTINE_EXIT_WITH_LITERAL)
    |=> o_work_we && o_work == $past(imm) && o_pc == $past(stk_top) && !o_carry_we)
    else $error("literal exit result wrong");

  chk_iret_enable: assert property (
    (state == S_RET && op == OP_INTERRUPT_EXIT && !i_irq_pending)
    |=> o_mie && o_pc_load && o_pc == $past(stk_top) && !o_work_we && !o_irq_take)
    else $error("interrupt exit did not restore pc and enable");

  chk_iret_pending: assert property (
    (state == S_RET && op == OP_INTERRUPT_EXIT && i_irq_pending)
    |=> o_irq_take && !o_mie && o_pc == $past(i_irq_vector) && stk_level == $past(stk_level))
    else $error("pending interrupt not serviced first");

  chk_rotl_mem: assert property (
    (state == S_WRITE && op == OP_ROTATE_LEFT_MEM)
    |=> o_mem_wr && o_mem_wdata == rrx_rol($past(i_mem_rdata)) && !o_carry_we && !o_work_we)
    else $error("rotate left memory wrong");

  chk_rotl_work: assert property (
    (state == S_WRITE && op == OP_ROTATE_LEFT_TO_WORK)
    |=> o_work_we && o_work == rrx_rol($past(i_mem_rdata)) && !o_mem_wr && !o_carry_we)
    else $error("rotate left to working register wrong");

  chk_rotlc_mem: assert property (
    (state == S_WRITE && op == OP_ROTATE_LEFT_VIA_FLAG_MEM)
    |=> o_mem_wr && o_carry_we && o_carry == $past(i_mem_rdata[7])
        && o_mem_wdata == rrx_rolc($past(i_mem_rdata), $past(i_carry)))
    else $error("rotate left via carry memory wrong");

  chk_rotlc_work: assert property (
    (state == S_WRITE && op == OP_ROTATE_LEFT_VIA_FLAG_TO_WORK)
    |=> o_work_we && !o_mem_wr && o_carry_we && o_carry == $past(i_mem_rdata[7])
        && o_work == rrx_rolc($past(i_mem_rdata), $past(i_carry)))
    else $error("rotate left via carry to working register wrong");

  chk_rotr_mem: assert property (
    (state == S_WRITE && op == OP_ROTATE_RIGHT_MEM)
    |=> o_mem_wr && o_mem_wdata == rrx_ror($past(i_mem_rdata)) && !o_carry_we)
    else $error("rotate right memory wrong");

  chk_rotr_work: assert property (
    (state == S_WRITE && op == OP_ROTATE_RIGHT_TO_WORK)
    |=> o_work_we && o_work == rrx_ror($past(i_mem_rdata)) && !o_mem_wr && !o_carry_we)
    else $error("rotate right to working register wrong");

  chk_rotrc_mem: assert property (
    (state == S_WRITE && op == OP_ROTATE_RIGHT_VIA_FLAG_MEM)
    |=> o_mem_wr && o_carry_we && o_carry == $past(i_mem_rdata[0])
        && o_mem_wdata == rrx_rorc($past(i_mem_rdata), $past(i_carry)))
    else $error("rotate right via carry memory wrong");

  chk_pop_unwind: assert property (
    (stk_pop && !i_push && stk_level != RRX_LEVEL_RST)
    |=> stk_level == $past(stk_level) - 4'h1)
    else $error("return pop did not unwind the stack");

  chk_rotate_latency: assert property (
    (state == S_IDLE && i_start && !rrx_is_return(i_op))
    |=> o_mem_rd ##1 !o_mem_rd ##1 o_done && !o_busy)
    else $error("rotate sequence timing wrong");

  cov_iret_pending: cover property (state == S_RET && iret_to_irq);
  cov_literal_exit: cover property (o_work_we && o_pc_load);
  cov_rotate_carry: cover property (o_carry_we && o_mem_wr);
  cov_back_to_back: cover property (o_done && state == S_IDLE && i_start);

endmodule

// *** tb/rrx_exec_bench.sv ***
// Self-checking bench for the return and rotate execution block.
`timescale 1ns/1ns
module rrx_exec_bench
  import rrx_pkg::*;
;
  logic                  i_mclk, i_nrst, i_start, i_carry, i_push, i_mie_clr, i_irq_pending;
  rrx_op_t               i_op;
  logic [RRX_DATA_W-1:0] i_imm, i_mem_rdata;
  logic [RRX_ADDR_W-1:0] i_addr;
  logic [RRX_PC_W-1:0]   i_push_pc, i_irq_vector;
  logic                  o_busy, o_done, o_mem_rd, o_mem_wr, o_work_we, o_carry_we;
  logic                  o_carry, o_pc_load, o_irq_take, o_mie;
  logic [RRX_ADDR_W-1:0] o_mem_addr;
  logic [RRX_DATA_W-1:0] o_mem_wdata, o_work;
  logic [RRX_PC_W-1:0]   o_pc;
  int                    miscompares = 0;
  int                    compares = 0;
  int                    lat, nrd, nwr, nbsy;
  logic [31:0]           seed = 32'h0000BE9F;
  logic [31:0]           r;
  logic [7:0]            rda, wd, wk;
  logic [12:0]           pc;
  logic                  wwe, cwe, co, pcl, tk;

  rrx_exec rrx_exec_i (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_start(i_start), .i_op(i_op), .i_imm(i_imm),
    .i_addr(i_addr), .i_mem_rdata(i_mem_rdata), .i_carry(i_carry), .i_push(i_push),
    .i_push_pc(i_push_pc), .i_mie_clr(i_mie_clr), .i_irq_pending(i_irq_pending),
    .i_irq_vector(i_irq_vector), .o_busy(o_busy), .o_done(o_done), .o_mem_rd(o_mem_rd),
    .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .o_work_we(o_work_we), .o_work(o_work), .o_carry_we(o_carry_we), .o_carry(o_carry),
    .o_pc_load(o_pc_load), .o_pc(o_pc), .o_irq_take(o_irq_take), .o_mie(o_mie)
  );

  initial
  begin
    i_mclk = 1'h0;
    forever #4 i_mclk = ~i_mclk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected {carry out, result}; plain rotates pass the old carry through.
  function automatic logic [8:0] rot(input rrx_op_t op, input logic [7:0] d, input logic c);
    case (op)
      OP_ROTATE_LEFT_MEM, OP_ROTATE_LEFT_TO_WORK: rot = {c, d[6:0], d[7]};
      OP_ROTATE_LEFT_VIA_FLAG_MEM, OP_ROTATE_LEFT_VIA_FLAG_TO_WORK: rot = {d[7], d[6:0], c};
      OP_ROTATE_RIGHT_MEM, OP_ROTATE_RIGHT_TO_WORK: rot = {c, d[0], d[7:1]};
      default: rot = {d[0], c, d[7:1]};
    endcase
  endfunction

  task automatic end_of_test;
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic note(input bit ok, input string m);
    compares++;
    if (!ok)
    begin
      miscompares++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic cmp_d(input logic [7:0] g, input logic [7:0] e);
    note(g === e, $sformatf("byte %h expected %h", g, e));
  endtask

  task automatic cmp_b(input logic g, input logic e);
    note(g === e, $sformatf("flag %b expected %b", g, e));
  endtask

  task automatic cmp_p(input logic [12:0] g, input logic [12:0] e);
    note(g === e, $sformatf("address %h expected %h", g, e));
  endtask

  task automatic cmp_n(input int g, input int e);
    note(g == e, $sformatf("count %0d expected %0d", g, e));
  endtask

  // Issues one instruction and captures the strobes of its completion cycle.
  // It returns in the done cycle, so the next issue starts back to back.
  task automatic issue(input rrx_op_t op, input logic [7:0] imm, d, input logic c);
    i_start = 1'h1;
    i_op = op;
    i_imm = imm;
    r = rnd();
    i_addr = r[7:0];
    i_mem_rdata = d;
    i_carry = c;
    lat = 0;
    nrd = 0;
    nwr = 0;
    nbsy = 0;
    do
    begin
      @(posedge i_mclk);
      #1;
      if (lat == 0)
        i_start = 1'h0;
      lat++;
      if (o_mem_rd === 1'h1)
      begin
        nrd++;
        rda = o_mem_addr;
      end
      if (o_mem_wr === 1'h1)
        nwr++;
      if (o_busy === 1'h1)
        nbsy++;
    end
    while (o_done !== 1'h1 && lat < 8);
    wd = o_mem_wdata;
    wk = o_work;
    wwe = o_work_we;
    cwe = o_carry_we;
    co = o_carry;
    pcl = o_pc_load;
    pc = o_pc;
    tk = o_irq_take;
  endtask

  // A push pulse leaves one idle cycle after it so that pushes never merge.
  task automatic push(input logic [12:0] p, input logic clr);
    i_push = 1'h1;
    i_push_pc = p;
    i_mie_clr = clr;
    @(posedge i_mclk);
    #1;
    i_push = 1'h0;
    i_mie_clr = 1'h0;
    @(posedge i_mclk);
    #1;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin : main
    rrx_op_t     op;
    logic [7:0]  d, imm;
    logic        c, mem, fl;
    logic [8:0]  e;
    logic [12:0] stk [3];
    logic [12:0] vec;
    i_nrst = 1'h0;
    i_start = 1'h0;
    i_op = OP_ROTATE_LEFT_MEM;
    i_imm = 8'h00;
    i_addr = 8'h00;
    i_mem_rdata = 8'h00;
    i_carry = 1'h0;
    i_push = 1'h0;
    i_push_pc = 13'h0000;
    i_mie_clr = 1'h0;
    i_irq_pending = 1'h0;
    i_irq_vector = 13'h0000;
    repeat (2) @(posedge i_mclk);
    #1;
    i_nrst = 1'h1;
    cmp_b(o_mie, 1'h0);
    // Corner bytes first, carrying the edge bit out and in, then random bytes.
    for (int k = 0; k < 42; k++)
    begin
      r = rnd();
      op = rrx_op_t'(4'h2 + 4'(k % 7));
      d = (k < 7) ? 8'h80 : (k < 14) ? 8'h01 : r[7:0];
      c = r[8];
      mem = op inside {OP_ROTATE_LEFT_MEM, OP_ROTATE_LEFT_VIA_FLAG_MEM,
                       OP_ROTATE_RIGHT_MEM, OP_ROTATE_RIGHT_VIA_FLAG_MEM};
      fl = op inside {OP_ROTATE_LEFT_VIA_FLAG_MEM, OP_ROTATE_LEFT_VIA_FLAG_TO_WORK,
                      OP_ROTATE_RIGHT_VIA_FLAG_MEM};
      e = rot(op, d, c);
      issue(op, 8'h00, d, c);
      cmp_n(lat, 3);
      cmp_n(nbsy, 2);
      cmp_n(nrd, 1);
      cmp_d(rda, i_addr);
      cmp_n(nwr, mem ? 1 : 0);
      cmp_b(wwe, !mem);
      cmp_d(mem ? wd : wk, e[7:0]);
      cmp_b(cwe, fl);
      if (fl)
        cmp_b(co, e[8]);
    end
    for (int n = 0; n < 3; n++)
    begin
      for (int j = 0; j < 3; j++)
      begin
        r = rnd();
        stk[j] = r[12:0];
        push(stk[j], 1'h1);
      end
      r = rnd();
      vec = r[12:0];
      i_irq_vector = vec;
      i_irq_pending = 1'h1;
      issue(OP_INTERRUPT_EXIT, 8'h00, 8'h00, 1'h0);
      i_irq_pending = 1'h0;
      cmp_n(lat, 2);
      cmp_b(tk, 1'h1);
      cmp_p(pc, vec);
      cmp_b(o_mie, 1'h0);
      for (int j = 2; j >= 0; j--)
      begin
        r = rnd();
        imm = r[7:0];
        issue(OP_SUBROUTINE_EXIT_WITH_LITERAL, imm, r[15:8], r[16]);
        cmp_n(lat, 2);
        cmp_n(nbsy, 1);
        cmp_b(pcl, 1'h1);
        cmp_p(pc, stk[j]);
        cmp_b(wwe, 1'h1);
        cmp_d(wk, imm);
        cmp_b(cwe, 1'h0);
        cmp_n(nwr, 0);
      end
      // The issue task draws a fresh address, so the pushed value is kept apart.
      r = rnd();
      stk[0] = r[12:0];
      push(stk[0], 1'h1);
      cmp_b(o_mie, 1'h0);
      issue(OP_INTERRUPT_EXIT, 8'h00, 8'h00, 1'h0);
      cmp_b(pcl, 1'h1);
      cmp_p(pc, stk[0]);
      cmp_b(tk, 1'h0);
      cmp_b(cwe, 1'h0);
      cmp_b(o_mie, 1'h1);
    end
    end_of_test();
  end

  // Whole run is under two hundred cycles; the limit leaves ample margin.
  initial
  begin
    #100000;
    miscompares++;
    end_of_test();
  end
endmodule
